/* File: hdl/dtc_pkg.sv */
package dtc_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int NUM_CH = 4;
    localparam int CNT_W = 16;
    localparam int ADDR_W = 12;

    // ------------------------------------------------------------
    // Register map (byte addresses, one aligned word each)
    // ------------------------------------------------------------
    localparam logic [11:0] OFS_COUNT_CH0 = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h010;
    localparam logic [11:0] OFS_CONTROL = 12'h014;
    localparam logic [11:0] OFS_WIDTH = 12'h018;
    localparam int OFS_COUNT_STEP = 4;

    // Status register fields: terminal count [3:0], busy [7:4]
    localparam int STAT_TC_LSB = 0;
    localparam int STAT_BUSY_LSB = 4;
    // Control register fields: write-one init [3:0], write-one start [7:4]
    localparam int CTRL_INIT_LSB = 0;
    localparam int CTRL_START_LSB = 4;

    // APB byte strobes that make a whole 16-bit access
    localparam logic [3:0] STRB_HALF = 4'h3;

    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic init;
        logic start;
        logic load;
        logic [CNT_W-1:0] load_val;
        logic step;
    } dtc_chan_cmd_t;

    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic busy;
        logic tc;
        logic done;
    } dtc_chan_stat_t;

endpackage : dtc_pkg

/* File: hdl/dtc_sync.sv */
`timescale 1ns/1ns
module dtc_sync #(
    parameter int W = 4
) (
    input wire logic clk, // Clock
    input wire logic srst, // Synchronous reset
    input wire logic [W-1:0] d_in, // Asynchronous inputs
    output logic [W-1:0] q_out // Synchronised inputs
);

    logic [W-1:0] meta_ff;

    // Second stage is the only reader of the first
    always_ff @(posedge clk) begin
        if (srst) begin
            meta_ff <= '0;
            q_out <= '0;
        end else begin
            meta_ff <= d_in;
            q_out <= meta_ff;
        end
    end

endmodule : dtc_sync

/* File: hdl/dtc_chan.sv */
`timescale 1ns/1ns
module dtc_chan (
    input wire logic clk, // Clock
    input wire logic srst, // Synchronous reset
    input wire dtc_pkg::dtc_chan_cmd_t cmd, // Commands for this channel
    output dtc_pkg::dtc_chan_stat_t stat // Live state of this channel
);

    logic [dtc_pkg::CNT_W-1:0] count_ff;
    logic [dtc_pkg::CNT_W-1:0] prog_ff;
    logic busy_ff;
    logic tc_ff;
    logic done_ff;
    logic [dtc_pkg::CNT_W:0] nxt_diff;
    logic borrow;

    assign nxt_diff = {1'b0, count_ff} - {1'b0, dtc_pkg::CNT_ONE};
    assign borrow = nxt_diff[dtc_pkg::CNT_W];

    // ------------------------------------------------------------
    // Counter and programmed copy
    // ------------------------------------------------------------
    // No reset on the count: content is undefined until software loads it
    always_ff @(posedge clk) begin
        if (cmd.load && !busy_ff) begin
            count_ff <= cmd.load_val;
            prog_ff <= cmd.load_val;
        end else if (busy_ff && cmd.step) begin
            if (borrow) begin
                count_ff <= prog_ff;
            end else begin
                count_ff <= nxt_diff[dtc_pkg::CNT_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Run state and terminal count
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            busy_ff <= 1'b0;
            tc_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            done_ff <= busy_ff && cmd.step && borrow;
            if (busy_ff && cmd.step && borrow) begin
                busy_ff <= 1'b0;
                tc_ff <= 1'b1;
            end else if (cmd.init) begin
                busy_ff <= 1'b0;
                tc_ff <= 1'b0;
            end else if (cmd.start) begin
                busy_ff <= 1'b1;
                tc_ff <= 1'b0;
            end
        end
    end

    assign stat.count = count_ff;
    assign stat.busy = busy_ff;
    assign stat.tc = tc_ff;
    assign stat.done = done_ff;

endmodule : dtc_chan

/* File: hdl/dtc_top.sv */
// Operation
// - Four 16-bit transfer count registers, one per channel 0 to 3.
// - A read during a run returns the live remaining count.
// - Every completed transfer lowers the count by one, for 8 or 16 bits.
// - The run ends when decrementing borrows out of the 16-bit counter.
// - Count registers accept only whole 16-bit accesses; byte accesses refused.
// - Count value N means N plus one transfers; FFFF means 65536.
// - Completion sets terminal count; software may then rewrite the count.
//
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/1ns
module dtc_top (
    input wire logic CLK, // System clock, 50 MHz
    input wire logic SRST, // Synchronous reset, active high
    input wire logic PSEL, // APB select
    input wire logic PENABLE, // APB access phase
    input wire logic PWRITE, // APB direction
    input wire logic [11:0] PADDR, // APB byte address
    input wire logic [31:0] PWDATA, // APB write data
    input wire logic [3:0] PSTRB, // APB byte strobes
    output logic [31:0] PRDATA, // APB read data
    output logic PREADY, // APB ready
    output logic PSLVERR, // APB error
    input wire logic [3:0] XFER_DONE, // Per-channel transfer done, from pins
    output logic [3:0] TC_FLAG, // Per-channel terminal count
    output logic [3:0] BUSY, // Per-channel run in progress
    output logic [3:0] SEQ_END // One-cycle pulse: sequence ended
);

    localparam int N = dtc_pkg::NUM_CH;

    // ------------------------------------------------------------
    // Synchronise external transfer events
    // ------------------------------------------------------------
    logic [N-1:0] xfer_sync;
    logic [N-1:0] xfer_prev_ff;
    logic [N-1:0] xfer_step;

    dtc_sync #(.W(N)) u_sync (
        .clk(CLK),
        .srst(SRST),
        .d_in(XFER_DONE),
        .q_out(xfer_sync)
    );

    always_ff @(posedge CLK) begin
        if (SRST) begin
            xfer_prev_ff <= '0;
        end else begin
            xfer_prev_ff <= xfer_sync;
        end
    end

    // One count per rising edge of the done level
    assign xfer_step = xfer_sync & ~xfer_prev_ff;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    logic setup;
    logic is_count;
    logic [1:0] ch_sel;
    logic is_status;
    logic is_control;
    logic is_width;
    logic half_ok;
    logic bad_acc;

    assign setup = PSEL && !PENABLE;
    assign is_count = (PADDR[11:4] == dtc_pkg::OFS_COUNT_CH0[11:4]) && (PADDR[1:0] == 2'h0);
    assign ch_sel = PADDR[3:2];
    assign is_status = PADDR == dtc_pkg::OFS_STATUS;
    assign is_control = PADDR == dtc_pkg::OFS_CONTROL;
    assign is_width = PADDR == dtc_pkg::OFS_WIDTH;
    // A write that does not carry both low lanes is not a 16-bit access
    assign half_ok = !PWRITE || (PSTRB[1:0] == dtc_pkg::STRB_HALF[1:0]);
    assign bad_acc = !(is_count || is_status || is_control || is_width) ||
                     (is_count && !half_ok);

    // Zero-wait slave: answer in the access phase
    logic access;
    logic wr_ok;

    assign access = PSEL && PENABLE;
    assign wr_ok = access && PWRITE && !bad_acc;

    // ------------------------------------------------------------
    // Software-held configuration
    // ------------------------------------------------------------
    // Transfer unit per channel: kept for software, count step is unit-independent
    logic [N-1:0] unit16_ff;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            unit16_ff <= '0;
        end else if (wr_ok && is_width) begin
            unit16_ff <= PWDATA[N-1:0];
        end
    end

    // ------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------
    dtc_pkg::dtc_chan_cmd_t cmd [N];
    dtc_pkg::dtc_chan_stat_t stat [N];
    logic [N-1:0] tc_vec;
    logic [N-1:0] busy_vec;
    logic [N-1:0] done_vec;

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_ch
            // Count writes during a run are ignored; software must wait for idle
            assign cmd[g].load = wr_ok && is_count && (ch_sel == 2'(g));
            assign cmd[g].load_val = PWDATA[dtc_pkg::CNT_W-1:0];
            assign cmd[g].init = wr_ok && is_control && PWDATA[dtc_pkg::CTRL_INIT_LSB + g];
            assign cmd[g].start = wr_ok && is_control &&
                                  PWDATA[dtc_pkg::CTRL_START_LSB + g];
            assign cmd[g].step = xfer_step[g];
            assign tc_vec[g] = stat[g].tc;
            assign busy_vec[g] = stat[g].busy;
            assign done_vec[g] = stat[g].done;

            dtc_chan u_chan (
                .clk(CLK),
                .srst(SRST),
                .cmd(cmd[g]),
                .stat(stat[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Read mux and response
    // ------------------------------------------------------------
    logic [31:0] rd_val;

    always_comb begin
        rd_val = 32'h0000_0000;
        if (is_count) begin
            rd_val[dtc_pkg::CNT_W-1:0] = stat[ch_sel].count;
        end else if (is_status) begin
            rd_val[dtc_pkg::STAT_TC_LSB +: N] = tc_vec;
            rd_val[dtc_pkg::STAT_BUSY_LSB +: N] = busy_vec;
        end else if (is_width) begin
            rd_val[N-1:0] = unit16_ff;
        end
    end

    // Answer registered in setup so PREADY is a flop, one wait-free access phase
    always_ff @(posedge CLK) begin
        if (SRST) begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h0000_0000;
        end else begin
            PREADY <= setup;
            PSLVERR <= setup && bad_acc;
            if (setup && !PWRITE && !bad_acc) begin
                PRDATA <= rd_val;
            end
        end
    end

    // ------------------------------------------------------------
    // Status outputs
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (SRST) begin
            TC_FLAG <= '0;
            BUSY <= '0;
            SEQ_END <= '0;
        end else begin
            TC_FLAG <= tc_vec;
            BUSY <= busy_vec;
            SEQ_END <= done_vec;
        end
    end

endmodule : dtc_top

/* File: testbench/dtc_props.sv */
`timescale 1ns/1ns
module dtc_props (
    input wire logic CLK, // Clock
    input wire logic SRST, // Reset
    input wire logic PSEL, // Select
    input wire logic PENABLE, // Access phase
    input wire logic PWRITE, // Direction
    input wire logic [11:0] PADDR, // Address
    input wire logic [3:0] PSTRB, // Strobes
    input wire logic [31:0] PRDATA, // Read data
    input wire logic PREADY, // Ready
    input wire logic PSLVERR, // Error
    input wire logic [3:0] TC_FLAG, // Terminal count
    input wire logic [3:0] BUSY, // Running
    input wire logic [3:0] SEQ_END // Run ended
);
    // ------------------------------------------------------------
    // Bus and run checks
    // ------------------------------------------------------------
    default clocking @(posedge CLK); endclocking
    default disable iff (SRST);
    sequence s_setup;
        PSEL && !PENABLE;
    endsequence
    sequence s_answer;
        PREADY ##1 !PREADY;
    endsequence
    AST_ANSWER: assert property (s_setup |=> s_answer)
        else $error("answer not single cycle");
    AST_ERR_READY: assert property (PSLVERR |-> PREADY)
        else $error("error without ready");
    AST_BYTE_REFUSED: assert property ((PSEL && !PENABLE && PWRITE && PADDR < 12'h010
        && PSTRB[1:0] != 2'h3) |=> PSLVERR) else $error("byte write accepted");
    AST_UNMAPPED: assert property ((PSEL && !PENABLE && PADDR > 12'h018) |=> PSLVERR)
        else $error("unmapped access accepted");
    AST_UPPER_ZERO: assert property ((PREADY && !PWRITE && PADDR < 12'h010)
        |-> PRDATA[31:16] == 16'h0) else $error("count upper half not zero");
    AST_END_PULSE: assert property ((|SEQ_END) |=> (SEQ_END & $past(SEQ_END)) == 4'h0)
        else $error("end pulse too long");
    AST_END_STATE: assert property ((|SEQ_END) |-> (SEQ_END & (BUSY | ~TC_FLAG)) == 4'h0)
        else $error("end without flag");
    AST_END_FROM_RUN: assert property ((|SEQ_END) |-> (SEQ_END & ~$past(BUSY)) == 4'h0)
        else $error("end while idle");
    AST_TC_CAUSE: assert property ((TC_FLAG & ~$past(TC_FLAG) & ~SEQ_END) == 4'h0)
        else $error("flag set without end");
endmodule : dtc_props

/* File: testbench/tb_dtc_top.sv */
`timescale 1ns/1ns
module tb_dtc_top;
    logic CLK, SRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, err;
    logic [11:0] PADDR;
    logic [31:0] PWDATA, PRDATA, rd;
    logic [3:0] PSTRB, XFER_DONE, TC_FLAG, BUSY, SEQ_END;
    int bad_count, n_checks;
    int ends [4];
    dtc_top DUT (.CLK(CLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .XFER_DONE(XFER_DONE), .TC_FLAG(TC_FLAG), .BUSY(BUSY),
        .SEQ_END(SEQ_END));
    // ------------------------------------------------------------
    // Clock, end counters and tasks
    // ------------------------------------------------------------
    initial begin
        CLK = 1'b0;
        forever #10 CLK = ~CLK;
    end
    always @(posedge CLK) for (int i = 0; i < 4; i++) if (SEQ_END[i] === 1'b1) ends[i]++;
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic [3:0] s);
        int i;
        @(posedge CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        PSTRB <= s;
        @(posedge CLK);
        PENABLE <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge CLK);
            if (PREADY === 1'b1) break;
        end
        if (i == 20) begin
            bad_count++;
            final_report();
        end
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'hf);
    endtask : wr
    task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, 4'h0);
        chk(what, rd, exp);
    endtask : rdc
    // Edge is held long enough to pass the two-flop synchroniser
    task automatic pulse(input int ch);
        @(posedge CLK);
        XFER_DONE[ch] <= 1'b1;
        repeat (3) @(posedge CLK);
        XFER_DONE[ch] <= 1'b0;
        repeat (6) @(posedge CLK);
    endtask : pulse
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        SRST = 1'b1;
        PSEL = 1'b0;
        PENABLE = 1'b0;
        PWRITE = 1'b0;
        PADDR = 12'h000;
        PWDATA = 32'h0;
        PSTRB = 4'h0;
        XFER_DONE = 4'h0;
        repeat (10) @(posedge CLK);
        SRST <= 1'b0;
        @(negedge CLK);
        chk("outputs", {20'h0, TC_FLAG, BUSY, SEQ_END}, 32'h0);
        for (int c = 0; c < 4; c++) begin
            wr(12'(4 * c), 32'hffffa5f0 | c);
            rdc("count", 12'(4 * c), 32'h0000a5f0 | c);
        end
        apb(1'b1, 12'h004, 32'h0, 4'h1);
        chk("byte err", {31'h0, err}, 32'h1);
        rdc("byte kept", 12'h004, 32'h0000a5f1);
        apb(1'b0, 12'h020, 32'h0, 4'h0);
        chk("unmapped", {31'h0, err}, 32'h1);
        wr(12'h000, 32'h2);
        wr(12'h014, 32'h10);
        // BUSY copies the channel state one cycle after the write lands
        repeat (2) @(negedge CLK);
        chk("busy", {28'h0, BUSY}, 32'h1);
        rdc("status run", 12'h010, 32'h10);
        pulse(0);
        rdc("live", 12'h000, 32'h1);
        wr(12'h018, 32'h1);
        rdc("width", 12'h018, 32'h1);
        pulse(0);
        rdc("live wide", 12'h000, 32'h0);
        pulse(0);
        @(negedge CLK);
        chk("ends", 32'(ends[0]), 32'h1);
        chk("tc busy", {24'h0, TC_FLAG, BUSY}, 32'h10);
        rdc("reload", 12'h000, 32'h2);
        rdc("status", 12'h010, 32'h1);
        wr(12'h00c, 32'h0);
        wr(12'h014, 32'h80);
        pulse(3);
        @(negedge CLK);
        chk("single", 32'(ends[3]), 32'h1);
        wr(12'h014, 32'h20);
        wr(12'h014, 32'h3);
        repeat (2) @(negedge CLK);
        chk("init", {24'h0, TC_FLAG, BUSY}, 32'h80);
        wr(12'h004, 32'h7);
        rdc("rewrite", 12'h004, 32'h7);
        pulse(2);
        rdc("idle", 12'h008, 32'h0000a5f2);
        final_report();
    end
endmodule : tb_dtc_top
bind dtc_top dtc_props u_props (.CLK(CLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .TC_FLAG(TC_FLAG), .BUSY(BUSY), .SEQ_END(SEQ_END));
